// File: spi_option_block.sv
// Purpose: spi option-control register with dma, interrupt and pin-direction logic
// Assumes: status event pulses come from the shifter on the same clock
// Notes:   link clock and data pins are sampled through two flops
// How it works
// - option register at index 1; bit 6 always reads zero.
// - match flag with match interrupt enable raises the interrupt.
// - tx dma enable requests dma when tx empty and system enabled.
// - tx dma enable off gives no request, on suppresses tx empty interrupt.
// - rx dma enable requests dma when rx full and system enabled.
// - rx dma enable off gives no request, on blocks rx full interrupt.
// - in slave mode mode-fault enable has no effect; select pin is input.
// - master with mode-fault enable off releases select pin to gpio.
// - master with mode-fault enable on uses pin as fault input or select output.
// - in bidirectional mode output enable decides whether the data driver drives.
// - bidirectional output enable zero turns the driver off; pin is input.
// - bidirectional output enable one drives the shared data pin.
// - bidirectional master uses mosi, slave uses miso as shared line.
// - in normal pin mode the bidirectional output enable is ignored.
// - clearing system enable idles the block and resets all status flags.
// - master with fault enable: select output enable picks output, else fault input.
// - pin select zero means separate pins, one means single-wire bidirectional.
`timescale 1ns/10ps
`default_nettype none
module spi_option_block #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output var  logic              awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output var  logic              wready,
   output var  logic [1:0]        bresp,
   output var  logic              bvalid,
   input  wire logic              bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output var  logic              arready,
   output var  logic [31:0]       rdata,
   output var  logic [1:0]        rresp,
   output var  logic              rvalid,
   input  wire logic              rready,
   // shifter events
   input  wire logic              rxFullSet,
   input  wire logic              txEmptySet,
   input  wire logic              matchSet,
   input  wire logic              rxServiced,
   input  wire logic              txServiced,
   input  wire logic              txBit,
   input  wire logic              selectAssert,
   // requests
   output var  logic              irq,
   output var  logic              txDmaReq,
   output var  logic              rxDmaReq,
   // pins
   input  wire logic              linkClk,
   input  wire logic              mosiIn,
   input  wire logic              misoIn,
   input  wire logic              selectIn,
   output var  logic              mosiOut,
   output var  logic              mosiOe_n,
   output var  logic              misoOut,
   output var  logic              misoOe_n,
   output var  logic              selectOut,
   output var  logic              selectOe_n,
   output var  logic              selectGpio
);

   logic [7:0]  option_reg, mainCtl_reg, capture_reg;
   logic [3:0]  status_reg;
   logic        awHeld_reg, wHeld_reg, awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [5:0]  awIdx_reg;
   logic [31:0] wdata_reg, rdata_reg;
   logic        wLane0_reg;
   logic [1:0]  bresp_reg, rresp_reg;
   logic        irq_reg, txDmaReq_reg, rxDmaReq_reg, linkPrev_reg;
   logic        mosiOut_reg, mosiOe_n_reg, misoOut_reg, misoOe_n_reg;
   logic        selectOut_reg, selectOe_n_reg, selectGpio_reg;
   logic [3:0]  pinSync;
   logic        awTake, wTake, arTake, doWrite;
   logic        awHeld_next, wHeld_next, bvalid_next, rvalid_next;
   logic [7:0]  wAddr, rAddr;
   logic        sysEn, isMaster, pinSel, bidir_output_enable, faultEn, faultInput, linkRise, dataIn;
   logic [3:0]  statusClr;

   spi_pin_sync #(.WIDTH(4)) u_sync (
      .clock   (clock),
      .rst_n   (rst_n),
      .pinIn   ({selectIn, misoIn, mosiIn, linkClk}),
      .pinSync (pinSync)
   );

   assign sysEn    = mainCtl_reg[spi_option_pkg::CTL_SYS_EN];
   assign isMaster = mainCtl_reg[spi_option_pkg::CTL_MASTER];
   assign pinSel   = option_reg[spi_option_pkg::OPT_PIN_SELECT];
   assign bidir_output_enable  = option_reg[spi_option_pkg::OPT_BIDIR_OE];
   assign faultEn  = option_reg[spi_option_pkg::OPT_MODE_FAULT_EN];
   // select pin watched for mode fault only in master with fault enable and no output
   assign faultInput = sysEn & isMaster & faultEn & ~mainCtl_reg[spi_option_pkg::CTL_SEL_OUT_EN];
   assign linkRise = pinSync[0] & ~linkPrev_reg;
   // data line by role and pin mode
   assign dataIn = pinSel ? (isMaster ? pinSync[1] : pinSync[2])
                          : (isMaster ? pinSync[2] : pinSync[1]);

   // axi handshakes
   assign awTake  = awvalid & awready_reg;
   assign wTake   = wvalid & wready_reg;
   assign arTake  = arvalid & arready_reg;
   assign doWrite = awHeld_reg & wHeld_reg & ~bvalid_reg;
   assign wAddr   = {awIdx_reg, 2'h0};
   assign rAddr   = {araddr[7:2], 2'h0};

   always_comb begin
      awHeld_next = awTake | (awHeld_reg & ~doWrite);
      wHeld_next  = wTake | (wHeld_reg & ~doWrite);
      bvalid_next = doWrite | (bvalid_reg & ~bready);
      rvalid_next = arTake | (rvalid_reg & ~rready);
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         awHeld_reg  <= 1'b0;
         wHeld_reg   <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         awIdx_reg   <= 6'h00;
         wdata_reg   <= 32'h0000_0000;
         wLane0_reg  <= 1'b0;
      end else begin
         awHeld_reg  <= awHeld_next;
         wHeld_reg   <= wHeld_next;
         bvalid_reg  <= bvalid_next;
         awready_reg <= ~awHeld_next & ~bvalid_next;
         wready_reg  <= ~wHeld_next & ~bvalid_next;
         if (awTake) begin
            awIdx_reg <= awaddr[7:2];
         end
         if (wTake) begin
            wdata_reg  <= wdata;
            wLane0_reg <= wstrb[0];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bresp_reg <= spi_option_pkg::RESP_OKAY;
      end else if (doWrite) begin
         case (wAddr)
            spi_option_pkg::MAIN_CTRL_ADDR,
            spi_option_pkg::OPTION_ADDR,
            spi_option_pkg::STATUS_ADDR,
            spi_option_pkg::CAPTURE_ADDR: bresp_reg <= spi_option_pkg::RESP_OKAY;
            default:                      bresp_reg <= spi_option_pkg::RESP_DECERR;
         endcase
      end
   end

   // control registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         option_reg  <= spi_option_pkg::OPTION_RESET;
         mainCtl_reg <= spi_option_pkg::MAIN_CTRL_RESET;
      end else if (doWrite && wLane0_reg) begin
         if (wAddr == spi_option_pkg::OPTION_ADDR) begin
            option_reg <= wdata_reg[7:0] & spi_option_pkg::OPTION_WRITE_MASK;
         end
         if (wAddr == spi_option_pkg::MAIN_CTRL_ADDR) begin
            mainCtl_reg <= wdata_reg[7:0] & spi_option_pkg::MAIN_CTRL_WRITE_MASK;
         end
      end
   end

   // status flags: set wins over clear, disable wins over all
   always_comb begin
      statusClr = 4'h0;
      if (doWrite && wLane0_reg && wAddr == spi_option_pkg::STATUS_ADDR) begin
         statusClr = wdata_reg[3:0];
      end
      statusClr[spi_option_pkg::ST_RX_FULL]  = statusClr[spi_option_pkg::ST_RX_FULL] | rxServiced;
      statusClr[spi_option_pkg::ST_TX_EMPTY] = statusClr[spi_option_pkg::ST_TX_EMPTY] | txServiced;
   end

   always_ff @(posedge clock) begin
      if (!rst_n || !sysEn) begin
         status_reg <= spi_option_pkg::STATUS_RESET;
      end else begin
         status_reg <= (status_reg & ~statusClr)
                     | {faultInput & ~pinSync[3], matchSet, txEmptySet, rxFullSet};
      end
   end

   // link capture, idle while disabled
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         linkPrev_reg <= 1'b0;
         capture_reg  <= 8'h00;
      end else begin
         linkPrev_reg <= pinSync[0];
         if (!sysEn) begin
            capture_reg <= 8'h00;
         end else if (linkRise) begin
            capture_reg <= {capture_reg[6:0], dataIn};
         end
      end
   end

   // interrupt and dma requests
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irq_reg      <= 1'b0;
         txDmaReq_reg <= 1'b0;
         rxDmaReq_reg <= 1'b0;
      end else begin
         txDmaReq_reg <= option_reg[spi_option_pkg::OPT_TX_DMA_EN] & sysEn
                       & status_reg[spi_option_pkg::ST_TX_EMPTY];
         rxDmaReq_reg <= option_reg[spi_option_pkg::OPT_RX_DMA_EN] & sysEn
                       & status_reg[spi_option_pkg::ST_RX_FULL];
         irq_reg <= (option_reg[spi_option_pkg::OPT_MATCH_IRQ_EN] & status_reg[spi_option_pkg::ST_MATCH])
                  | (mainCtl_reg[spi_option_pkg::CTL_TX_IRQ_EN] & ~option_reg[spi_option_pkg::OPT_TX_DMA_EN]
                     & status_reg[spi_option_pkg::ST_TX_EMPTY])
                  | (mainCtl_reg[spi_option_pkg::CTL_RX_IRQ_EN] & ~option_reg[spi_option_pkg::OPT_RX_DMA_EN]
                     & status_reg[spi_option_pkg::ST_RX_FULL]);
      end
   end

   // data pin drivers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mosiOut_reg  <= 1'b0;
         misoOut_reg  <= 1'b0;
         mosiOe_n_reg <= 1'b1;
         misoOe_n_reg <= 1'b1;
      end else begin
         mosiOut_reg  <= txBit;
         misoOut_reg  <= txBit;
         mosiOe_n_reg <= 1'b1;
         misoOe_n_reg <= 1'b1;
         if (sysEn) begin
            if (pinSel) begin
               if (isMaster) begin
                  mosiOe_n_reg <= ~bidir_output_enable;
               end else begin
                  misoOe_n_reg <= ~bidir_output_enable;
               end
            end else if (isMaster) begin
               mosiOe_n_reg <= 1'b0;
            end else begin
               misoOe_n_reg <= pinSync[3];
            end
         end
      end
   end

   // select pin
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         selectOut_reg  <= 1'b1;
         selectOe_n_reg <= 1'b1;
         selectGpio_reg <= 1'b0;
      end else begin
         selectOut_reg  <= ~selectAssert;
         selectOe_n_reg <= 1'b1;
         selectGpio_reg <= 1'b0;
         if (sysEn && isMaster) begin
            if (!faultEn) begin
               selectGpio_reg <= 1'b1;
            end else begin
               selectOe_n_reg <= ~mainCtl_reg[spi_option_pkg::CTL_SEL_OUT_EN];
            end
         end
      end
   end

   // read channel
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rvalid_reg  <= 1'b0;
         arready_reg <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rresp_reg   <= spi_option_pkg::RESP_OKAY;
      end else begin
         rvalid_reg  <= rvalid_next;
         arready_reg <= ~rvalid_next;
         if (arTake) begin
            rresp_reg <= spi_option_pkg::RESP_OKAY;
            case (rAddr)
               spi_option_pkg::MAIN_CTRL_ADDR: rdata_reg <= {24'h00_0000, mainCtl_reg};
               spi_option_pkg::OPTION_ADDR:    rdata_reg <= {24'h00_0000,
                  option_reg & spi_option_pkg::OPTION_WRITE_MASK};
               spi_option_pkg::STATUS_ADDR:    rdata_reg <= {28'h000_0000, status_reg};
               spi_option_pkg::CAPTURE_ADDR:   rdata_reg <= {24'h00_0000, capture_reg};
               default: begin
                  rdata_reg <= 32'h0000_0000;
                  rresp_reg <= spi_option_pkg::RESP_DECERR;
               end
            endcase
         end
      end
   end

   assign awready    = awready_reg;
   assign wready     = wready_reg;
   assign bvalid     = bvalid_reg;
   assign bresp      = bresp_reg;
   assign arready    = arready_reg;
   assign rvalid     = rvalid_reg;
   assign rdata      = rdata_reg;
   assign rresp      = rresp_reg;
   assign irq        = irq_reg;
   assign txDmaReq   = txDmaReq_reg;
   assign rxDmaReq   = rxDmaReq_reg;
   assign mosiOut    = mosiOut_reg;
   assign mosiOe_n   = mosiOe_n_reg;
   assign misoOut    = misoOut_reg;
   assign misoOe_n   = misoOe_n_reg;
   assign selectOut  = selectOut_reg;
   assign selectOe_n = selectOe_n_reg;
   assign selectGpio = selectGpio_reg;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   reserved_zero_a: assert property (!option_reg[spi_option_pkg::OPT_RESERVED])
      else $error("reserved option bit set");
   match_irq_a: assert property (option_reg[spi_option_pkg::OPT_MATCH_IRQ_EN]
         && status_reg[spi_option_pkg::ST_MATCH] |=> irq)
      else $error("match interrupt missing");
   tx_dma_a: assert property (txDmaReq == ($past(option_reg[spi_option_pkg::OPT_TX_DMA_EN]) && $past(sysEn)
         && $past(status_reg[spi_option_pkg::ST_TX_EMPTY])))
      else $error("tx dma request wrong");
   tx_irq_block_a: assert property (option_reg[spi_option_pkg::OPT_TX_DMA_EN]
         && !option_reg[spi_option_pkg::OPT_MATCH_IRQ_EN] && !mainCtl_reg[spi_option_pkg::CTL_RX_IRQ_EN]
         ##1 $stable(option_reg) && $stable(mainCtl_reg) |-> !irq)
      else $error("tx empty interrupt not suppressed");
   rx_dma_a: assert property (rxDmaReq |-> $past(sysEn) && $past(status_reg[spi_option_pkg::ST_RX_FULL])
         && $past(option_reg[spi_option_pkg::OPT_RX_DMA_EN]))
      else $error("rx dma request without cause");
   rx_dma_drop_a: assert property (!option_reg[spi_option_pkg::OPT_RX_DMA_EN] |=> !rxDmaReq)
      else $error("rx dma request while disabled");
   slave_select_a: assert property (!isMaster |=> selectOe_n && !selectGpio)
      else $error("slave select pin not an input");
   gpio_release_a: assert property (sysEn && isMaster && !faultEn |=> selectGpio && selectOe_n)
      else $error("select pin not released");
   bidir_drive_a: assert property (sysEn && pinSel && isMaster |=> mosiOe_n == !$past(bidir_output_enable) && misoOe_n)
      else $error("shared data pin drive wrong");
   normal_pins_a: assert property (sysEn && !pinSel && isMaster |=> !mosiOe_n && misoOe_n)
      else $error("normal pin mode drive wrong");
   disable_idle_a: assert property (!sysEn |=> status_reg == 4'h0 && mosiOe_n && misoOe_n)
      else $error("disable did not idle");
   dma_release_a: assert property (txDmaReq && !status_reg[spi_option_pkg::ST_TX_EMPTY] |=> !txDmaReq)
      else $error("tx dma request stuck");

   tx_dma_c:    cover property (txDmaReq ##[1:20] !txDmaReq);
   bidir_out_c: cover property (pinSel && !mosiOe_n);
   fault_c:     cover property (status_reg[spi_option_pkg::ST_MODE_FAULT]);
   capture_c:   cover property (sysEn && linkRise);

endmodule : spi_option_block
`default_nettype wire

// File: spi_option_pkg.sv
// Purpose: shared constants for the spi option-control block
// Assumes: 32-bit axi4-lite register bus, 8-bit registers in the low byte lane
// Notes:   byte address of the option register is four times its index
package spi_option_pkg;

   // register indices and byte addresses
   localparam logic [2:0] OPTION_INDEX      = 3'h1;
   localparam logic [7:0] MAIN_CTRL_ADDR    = 8'h00;
   localparam logic [7:0] OPTION_ADDR       = {3'h0, OPTION_INDEX, 2'h0};
   localparam logic [7:0] STATUS_ADDR       = 8'h0C;
   localparam logic [7:0] CAPTURE_ADDR      = 8'h10;

   // option register fields
   localparam int OPT_MATCH_IRQ_EN  = 7;
   localparam int OPT_RESERVED      = 6;
   localparam int OPT_TX_DMA_EN     = 5;
   localparam int OPT_MODE_FAULT_EN = 4;
   localparam int OPT_BIDIR_OE      = 3;
   localparam int OPT_RX_DMA_EN     = 2;
   localparam int OPT_STOP_IN_WAIT  = 1;
   localparam int OPT_PIN_SELECT    = 0;
   localparam logic [7:0] OPTION_WRITE_MASK = 8'hBF;
   localparam logic [7:0] OPTION_RESET      = 8'h00;

   // main control fields
   localparam int CTL_RX_IRQ_EN   = 7;
   localparam int CTL_SYS_EN      = 6;
   localparam int CTL_TX_IRQ_EN   = 5;
   localparam int CTL_MASTER      = 4;
   localparam int CTL_SEL_OUT_EN  = 1;
   localparam logic [7:0] MAIN_CTRL_WRITE_MASK = 8'hF2;
   localparam logic [7:0] MAIN_CTRL_RESET      = 8'h00;

   // status fields, write one to clear
   localparam int ST_RX_FULL    = 0;
   localparam int ST_TX_EMPTY   = 1;
   localparam int ST_MATCH      = 2;
   localparam int ST_MODE_FAULT = 3;
   localparam logic [3:0] STATUS_RESET = 4'h0;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : spi_option_pkg

// File: spi_pin_sync.sv
// Purpose: two-flop synchronisers for pins from outside the clock domain
// Assumes: each bit is an independent level
// Notes:   the first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module spi_pin_sync #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // pins
   input  wire logic [WIDTH-1:0] pinIn,
   output var  logic [WIDTH-1:0] pinSync
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            stage1_reg[i] <= 1'b0;
            stage2_reg[i] <= 1'b0;
         end else begin
            stage1_reg[i] <= pinIn[i];
            stage2_reg[i] <= stage1_reg[i];
         end
      end
   end

   assign pinSync = stage2_reg;

endmodule : spi_pin_sync
`default_nettype wire

// File: spi_far_device.sv
// Purpose: far-side spi device model driving the link clock and pins
// Assumes: every shared line has a pull-up
// Notes:   link clock idles low and runs only inside a frame
`timescale 1ns/10ps
`default_nettype none
module spi_far_device (
   // frame control
   input  wire logic       go,
   input  wire logic [7:0] byteOut,
   input  wire logic       selLow,
   // device pin drivers
   input  wire logic       mosiOut,
   input  wire logic       mosiOe_n,
   input  wire logic       misoOut,
   input  wire logic       misoOe_n,
   input  wire logic       selectOut,
   input  wire logic       selectOe_n,
   // resolved pins
   output var  logic       linkClk,
   output wire logic       mosiIn,
   output wire logic       misoIn,
   output wire logic       selectIn
);
   logic partDrive;
   logic partVal;
   // undriven lines float up to the pull-up level
   assign mosiIn   = !mosiOe_n ? mosiOut : 1'b1;
   assign misoIn   = !misoOe_n ? misoOut : (partDrive ? partVal : 1'b1);
   assign selectIn = !selectOe_n ? selectOut : !selLow;
   initial begin
      linkClk   = 1'b0;
      partDrive = 1'b0;
      partVal   = 1'b1;
   end
   // msb first, data changes while clock is low
   always @(posedge go) begin
      partDrive = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         partVal = byteOut[i];
         #62.5 linkClk = 1'b1;
         #62.5 linkClk = 1'b0;
      end
      partDrive = 1'b0;
   end
endmodule : spi_far_device
`default_nettype wire

// File: test_spi_option_block.sv
// Purpose: self-checking bench for the spi option-control block
// Assumes: answers arrive by handshake; flags and requests lag their causes
// Notes:   one task per scenario
`timescale 1ns/10ps
`default_nettype none
module test_spi_option_block;
   logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr, byteOut;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [4:0] evts;
   logic txBit, selectAssert, irq, txDmaReq, rxDmaReq, go, selLow, linkClk, mosiIn, misoIn, selectIn;
   logic mosiOut, mosiOe_n, misoOut, misoOe_n, selectOut, selectOe_n, selectGpio;
   int n_mismatch, checked, cycles;
   localparam logic [7:0] OPT = spi_option_pkg::OPTION_ADDR;
   localparam logic [7:0] MAIN = spi_option_pkg::MAIN_CTRL_ADDR;
   spi_option_block i_spi_option_block (.clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .rxFullSet(evts[0]), .txEmptySet(evts[1]),
      .matchSet(evts[2]), .rxServiced(evts[3]), .txServiced(evts[4]), .txBit(txBit),
      .selectAssert(selectAssert), .irq(irq), .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq), .linkClk(linkClk),
      .mosiIn(mosiIn), .misoIn(misoIn), .selectIn(selectIn), .mosiOut(mosiOut), .mosiOe_n(mosiOe_n),
      .misoOut(misoOut), .misoOe_n(misoOe_n), .selectOut(selectOut), .selectOe_n(selectOe_n),
      .selectGpio(selectGpio));
   spi_far_device i_spi_far_device (.go(go), .byteOut(byteOut), .selLow(selLow), .mosiOut(mosiOut),
      .mosiOe_n(mosiOe_n), .misoOut(misoOut), .misoOe_n(misoOe_n), .selectOut(selectOut),
      .selectOe_n(selectOe_n), .linkClk(linkClk), .mosiIn(mosiIn), .misoIn(misoIn), .selectIn(selectIn));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task end_of_test;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task wcyc(input int n);
      repeat (n) @(posedge clock);
   endtask : wcyc
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      forever begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      r = bresp;
      bready <= 1'b0;
      @(posedge clock);
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      forever begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata; r = rresp;
      rready <= 1'b0;
      @(posedge clock);
   endtask : rd
   task pulse(input logic [4:0] m);
      @(posedge clock) evts <= m;
      @(posedge clock) evts <= 5'h00;
   endtask : pulse
   task reg_map;
      logic [31:0] d; logic [1:0] r;
      rd(OPT, d, r); chk("option reset", d, 32'h00000000);
      chk("irq reset", {irq, txDmaReq, rxDmaReq, mosiOe_n, misoOe_n, selectOe_n}, 32'h00000007);
      wr(OPT, 32'h000000BF, r); chk("option write resp", r, spi_option_pkg::RESP_OKAY);
      rd(OPT, d, r);
      chk("option readback", d, 32'h000000BF);
      chk("option resp", r, spi_option_pkg::RESP_OKAY);
      wstrb <= 4'hE; wr(OPT, 32'h00000000, r); wstrb <= 4'hF;
      rd(OPT, d, r); chk("lane off kept", d, 32'h000000BF);
      wr(8'h08, 32'h00000000, r); chk("unmapped write resp", r, spi_option_pkg::RESP_DECERR);
      rd(8'h08, d, r); chk("unmapped resp", r, spi_option_pkg::RESP_DECERR);
   endtask : reg_map
   task tx_dma;
      logic [1:0] r;
      wr(MAIN, 32'h00000060, r); wr(OPT, 32'h00000020, r);
      pulse(5'h02); wcyc(3);
      chk("tx dma on", txDmaReq, 1'b1);
      chk("tx irq held", irq, 1'b0);
      pulse(5'h10); wcyc(3); chk("tx dma drop", txDmaReq, 1'b0);
      pulse(5'h02); wr(OPT, 32'h00000000, r); wcyc(3);
      chk("tx dma off", {txDmaReq, irq}, 32'h00000001);
      pulse(5'h10);
   endtask : tx_dma
   task rx_dma;
      logic [31:0] d; logic [1:0] r;
      wr(MAIN, 32'h000000C0, r); wr(OPT, 32'h00000004, r);
      pulse(5'h01); wcyc(3);
      chk("rx dma on", {rxDmaReq, irq}, 32'h00000002);
      wr(MAIN, 32'h00000080, r); wcyc(3); chk("rx dma sys off", rxDmaReq, 1'b0);
      rd(spi_option_pkg::STATUS_ADDR, d, r); chk("status cleared", d, 32'h00000000);
      wr(MAIN, 32'h000000C0, r); wr(OPT, 32'h00000000, r);
      pulse(5'h01); wcyc(3); chk("rx dma off", {rxDmaReq, irq}, 32'h00000001);
      pulse(5'h08);
   endtask : rx_dma
   task match_irq;
      logic [1:0] r;
      wr(MAIN, 32'h00000040, r); pulse(5'h04); wcyc(3);
      chk("match polled", irq, 1'b0);
      wr(OPT, 32'h00000080, r); wcyc(3); chk("match irq", irq, 1'b1);
      wr(spi_option_pkg::STATUS_ADDR, 32'h00000004, r); wcyc(3); chk("match clear", irq, 1'b0);
   endtask : match_irq
   task select_pin;
      logic [31:0] d; logic [1:0] r;
      wr(MAIN, 32'h00000040, r); wr(OPT, 32'h00000010, r); wcyc(3);
      chk("slave select", {selectGpio, selectOe_n}, 32'h00000001);
      wr(MAIN, 32'h00000050, r); wr(OPT, 32'h00000000, r); wcyc(3);
      chk("master gpio", selectGpio, 1'b1);
      wr(OPT, 32'h00000010, r); wr(MAIN, 32'h00000052, r); selectAssert <= 1'b1; wcyc(3);
      chk("select out", {selectGpio, selectOe_n, selectOut}, 32'h00000000);
      selectAssert <= 1'b0; wr(MAIN, 32'h00000050, r); selLow <= 1'b1; wcyc(6);
      rd(spi_option_pkg::STATUS_ADDR, d, r);
      chk("mode fault", d[spi_option_pkg::ST_MODE_FAULT], 1'b1);
      selLow <= 1'b0;
   endtask : select_pin
   task bidir;
      logic [1:0] r;
      wr(MAIN, 32'h00000050, r); wr(OPT, 32'h00000001, r); wcyc(3);
      chk("bidir in", {mosiOe_n, misoOe_n}, 32'h00000003);
      wr(OPT, 32'h00000009, r); txBit <= 1'b1; wcyc(3);
      chk("bidir master out", {mosiOe_n, misoOe_n, mosiOut}, 32'h00000003);
      wr(MAIN, 32'h00000040, r); selLow <= 1'b1; wcyc(6);
      chk("bidir slave out", {mosiOe_n, misoOe_n, misoOut}, 32'h00000005);
      selLow <= 1'b0; wr(MAIN, 32'h00000050, r);
      wr(OPT, 32'h00000008, r); wcyc(3); chk("normal oe set", mosiOe_n, 1'b0);
      wr(OPT, 32'h00000000, r); wcyc(3); chk("normal oe clear", mosiOe_n, 1'b0);
   endtask : bidir
   task capture;
      logic [31:0] d; logic [1:0] r;
      byteOut <= 8'hA5; @(posedge clock) go <= 1'b1;
      wcyc(300); go <= 1'b0;
      rd(spi_option_pkg::CAPTURE_ADDR, d, r); chk("capture byte", d[7:0], 8'hA5);
   endtask : capture
   initial begin
      rst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      awaddr = 8'h00; araddr = 8'h00; wdata = 32'h00000000; wstrb = 4'hF; evts = 5'h00;
      txBit = 1'b0; selectAssert = 1'b0; go = 1'b0; selLow = 1'b0; byteOut = 8'h00;
      n_mismatch = 0; checked = 0; cycles = 0;
      wcyc(4);
      rst_n <= 1'b1;
      wcyc(2);
      reg_map(); tx_dma(); rx_dma(); match_irq(); select_pin(); bidir(); capture();
      end_of_test();
   end
endmodule : test_spi_option_block
`default_nettype wire
